// [verilog/racpt_top.sv]
// Auto-calibration selection and power-on timeout for the radio core
// What this block does
// - Setting 0: no automatic calibration; only the strobe calibrates.
// - Setting 1: calibrate on idle to receive, transmit or synth-on.
// - Setting 2: calibrate on receive or transmit back to idle.
// - Setting 3: calibrate on every fourth leave of receive/transmit.
// - Timeout field counts ripple expiries after settling before ready.
// - Timeout 0 needs one expiry, timeout 1 needs sixteen.
// - Timeout 2 needs sixty-four expiries, timeout 3 two hundred fifty-six.
// - Oscillator-settled rises exactly when chip-ready-low falls.
`timescale 1ns/100ps
module racpt_top
   import racpt_pkg::*;
(
   input  wire logic           core_clk,
   input  wire logic           reset_n,
   input  wire racpt_reg_req_t reg_req,
   input  wire logic           crystal_oscillator_stable,
   input  wire racpt_radio_t   radio_state,
   input  wire logic           calibrate_strobe,
   output logic [7:0]          reg_rdata,
   output logic                cal_start,
   output logic                chip_ready_low,
   output logic                oscillator_settled
);
   logic [1:0]   synth_calibration_select_r;
   logic [1:0]   power_on_expiry_select_r;
   logic [1:0]   low_bits_r;
   racpt_radio_t prev_state_r;
   logic [1:0]   leave_cnt_r;
   logic [8:0]   exp_cnt_r;
   logic         done_r;
   logic         expire;
   logic         enter_rf;
   logic         leave_rf;
   logic         auto_cal;

   // Register decode shared by the write and read paths
   function automatic logic cfg_hit(input logic [7:0] addr);
      cfg_hit = addr == RACPT_CFG1_ADDR;
   endfunction

   function automatic logic rf_busy(input racpt_radio_t st);
      rf_busy = st == RACPT_RX || st == RACPT_TX;
   endfunction

   // Register write; low two bits are stored but steer nothing here
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         synth_calibration_select_r <= RACPT_CAL_RST;
         power_on_expiry_select_r   <= RACPT_PO_RST;
         low_bits_r                 <= RACPT_LOW_RST;
      end else if (reg_req.wr && cfg_hit(reg_req.addr)) begin
         synth_calibration_select_r <=
            reg_req.wdata[RACPT_CAL_HI:RACPT_CAL_LO];
         power_on_expiry_select_r   <=
            reg_req.wdata[RACPT_PO_HI:RACPT_PO_LO];
         low_bits_r                 <= reg_req.wdata[1:0];
      end
   end

   // Unmapped addresses and unused top bits read as zero
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd && cfg_hit(reg_req.addr)) begin
         reg_rdata <= {2'b00, synth_calibration_select_r,
                       power_on_expiry_select_r, low_bits_r};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         prev_state_r <= RACPT_IDLE;
      end else begin
         prev_state_r <= radio_state;
      end
   end

   assign enter_rf = prev_state_r == RACPT_IDLE &&
                     (rf_busy(radio_state) || radio_state == RACPT_FSON);
   assign leave_rf = rf_busy(prev_state_r) && radio_state == RACPT_IDLE;

   // Counts leaves only in setting 3 so the fourth one is deterministic
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         leave_cnt_r <= 2'h0;
      end else if (leave_rf &&
                   synth_calibration_select_r == RACPT_CAL_FOURTH) begin
         leave_cnt_r <= leave_cnt_r + 2'h1;
      end
   end

   always_comb begin
      unique case (synth_calibration_select_r)
         RACPT_CAL_NEVER:  auto_cal = 1'b0;
         RACPT_CAL_ENTER:  auto_cal = enter_rf;
         RACPT_CAL_LEAVE:  auto_cal = leave_rf;
         RACPT_CAL_FOURTH: auto_cal = leave_rf &&
                              leave_cnt_r == RACPT_LEAVE_WRAP;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cal_start <= 1'b0;
      end else begin
         cal_start <= calibrate_strobe || auto_cal;
      end
   end

   racpt_ripple u_ripple (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .run      (crystal_oscillator_stable && !done_r),
      .expire   (expire)
   );

   // Oscillator loss clears the count so each start waits in full
   always_ff @(posedge core_clk) begin
      if (!reset_n || !crystal_oscillator_stable) begin
         exp_cnt_r <= 9'h000;
         done_r    <= 1'b0;
      end else if (expire && !done_r) begin
         exp_cnt_r <= exp_cnt_r + 9'h001;
         if (exp_cnt_r + 9'h001 ==
             racpt_expiries(power_on_expiry_select_r)) begin
            done_r <= 1'b1;
         end
      end
   end

   // Both indications share one flop source so they move together
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         chip_ready_low     <= 1'b1;
         oscillator_settled <= 1'b0;
      end else begin
         chip_ready_low     <= !done_r;
         oscillator_settled <= done_r;
      end
   end

   // Named behaviours used by the properties below; all but s_leave_in_fourth span more than one cycle
   sequence s_leave_in_fourth;
      synth_calibration_select_r == RACPT_CAL_FOURTH && leave_rf;
   endsequence

   sequence s_osc_drop;
      crystal_oscillator_stable ##1 !crystal_oscillator_stable;
   endsequence

   sequence s_ready_back;
      ##1 (chip_ready_low && !oscillator_settled);
   endsequence

   sequence s_done_rise;
      !done_r ##1 done_r;
   endsequence

   a_never_cal: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (synth_calibration_select_r == RACPT_CAL_NEVER && !calibrate_strobe)
      |=> !cal_start)
      else $error("automatic calibration in setting 0");
   a_strobe_cal: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      calibrate_strobe |=> cal_start)
      else $error("calibrate strobe ignored");
   a_enter_cal: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (synth_calibration_select_r == RACPT_CAL_ENTER && enter_rf)
      |=> cal_start)
      else $error("no calibration on entry");
   a_enter_only: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (synth_calibration_select_r == RACPT_CAL_ENTER && !enter_rf &&
       !calibrate_strobe) |=> !cal_start)
      else $error("calibration outside entry");
   a_leave_cal: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (synth_calibration_select_r == RACPT_CAL_LEAVE && leave_rf)
      |=> cal_start)
      else $error("no calibration on leave");
   a_leave_only: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (synth_calibration_select_r == RACPT_CAL_LEAVE && !leave_rf &&
       !calibrate_strobe) |=> !cal_start)
      else $error("calibration outside leave");
   a_fourth_skip: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      s_leave_in_fourth ##0 (leave_cnt_r != RACPT_LEAVE_WRAP &&
       !calibrate_strobe) |=> !cal_start)
      else $error("calibration before fourth leave");
   a_fourth_fire: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      s_leave_in_fourth ##0 (leave_cnt_r == RACPT_LEAVE_WRAP)
      |=> cal_start)
      else $error("no calibration on fourth leave");
   a_fourth_count: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      s_leave_in_fourth |=> leave_cnt_r == $past(leave_cnt_r) + 2'h1)
      else $error("leave count did not advance");
   a_ready_pair: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      chip_ready_low != oscillator_settled)
      else $error("ready and settled disagree");
   a_done_ready: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      s_done_rise |=> (!chip_ready_low && oscillator_settled))
      else $error("ready late after count done");
   a_osc_restart: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !crystal_oscillator_stable |=> ##1 chip_ready_low)
      else $error("ready without oscillator");
   a_drop_ready: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      s_osc_drop |=> s_ready_back)
      else $error("ready kept after oscillator loss");
   a_count_bound: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      exp_cnt_r <= racpt_expiries(power_on_expiry_select_r))
      else $error("expiry count overran");
   a_ready_count: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      $fell(chip_ready_low) |-> $past(exp_cnt_r) ==
         racpt_expiries($past(power_on_expiry_select_r, 2)))
      else $error("ready fell at wrong expiry count");
   a_done_count: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      $rose(done_r) |-> exp_cnt_r ==
         racpt_expiries($past(power_on_expiry_select_r)))
      else $error("ready at wrong expiry count");
endmodule

// [verilog/racpt_pkg.sv]
// Package: register map, field layout and timing constants for the block
package racpt_pkg;
   localparam logic [7:0] RACPT_CFG1_ADDR   = 8'h17;
   localparam int         RACPT_CAL_HI      = 5;
   localparam int         RACPT_CAL_LO      = 4;
   localparam int         RACPT_PO_HI       = 3;
   localparam int         RACPT_PO_LO       = 2;
   localparam logic [1:0] RACPT_CAL_RST     = 2'h0;
   localparam logic [1:0] RACPT_PO_RST      = 2'h1;
   localparam logic [1:0] RACPT_LOW_RST     = 2'h0;
   localparam logic [1:0] RACPT_CAL_NEVER   = 2'h0;
   localparam logic [1:0] RACPT_CAL_ENTER   = 2'h1;
   localparam logic [1:0] RACPT_CAL_LEAVE   = 2'h2;
   localparam logic [1:0] RACPT_CAL_FOURTH  = 2'h3;
   localparam logic [8:0] RACPT_EXP_0       = 9'h001;
   localparam logic [8:0] RACPT_EXP_1       = 9'h010;
   localparam logic [8:0] RACPT_EXP_2       = 9'h040;
   localparam logic [8:0] RACPT_EXP_3       = 9'h100;
   localparam int         RACPT_RIPPLE_BITS = 6;
   localparam logic [1:0] RACPT_LEAVE_WRAP  = 2'h3;

   typedef enum logic [3:0] {
      RACPT_IDLE = 4'h1,
      RACPT_RX   = 4'h2,
      RACPT_TX   = 4'h4,
      RACPT_FSON = 4'h8
   } racpt_radio_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } racpt_reg_req_t;

   function automatic logic [8:0] racpt_expiries(input logic [1:0] sel);
      unique case (sel)
         2'h0: racpt_expiries = RACPT_EXP_0;
         2'h1: racpt_expiries = RACPT_EXP_1;
         2'h2: racpt_expiries = RACPT_EXP_2;
         2'h3: racpt_expiries = RACPT_EXP_3;
      endcase
   endfunction
endpackage

// [verilog/racpt_ripple.sv]
// Six-bit ripple counter that pulses once per expiry
`timescale 1ns/100ps
module racpt_ripple
   import racpt_pkg::*;
#(
   parameter int W = RACPT_RIPPLE_BITS
) (
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic run,
   output logic      expire
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge core_clk) begin
      if (!reset_n || !run) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign expire = run && (cnt_r == {W{1'b1}});

   a_ripple_period: assert property (@(posedge core_clk)
      disable iff (!reset_n) expire |=> !expire)
      else $error("ripple expiry repeated");
endmodule

// [tb/racpt_tb.sv]
// Self-checking bench for auto-calibration and power-on timeout
`timescale 1ns/100ps
module testbench
   import racpt_pkg::*;
;
   logic           core_clk = 1'b0;
   logic           reset_n = 1'b0;
   logic           crystal_oscillator_stable = 1'b0;
   logic           calibrate_strobe = 1'b0;
   racpt_reg_req_t reg_req = '0;
   racpt_radio_t   radio_state = RACPT_IDLE;
   racpt_radio_t   prev_st, next_st;
   logic [7:0]     reg_rdata;
   logic           cal_start, chip_ready_low, oscillator_settled;
   integer         seed = 91, miscompares = 0, checks = 0;
   integer         cal_seen = 0, cal_exp = 0, leaves = 0, cyc, m, s, lo;
   logic           lv;
   int             n_tab [4] = '{1, 16, 64, 256};

   racpt_top dut (
      .core_clk                  (core_clk),
      .reset_n                   (reset_n),
      .reg_req                   (reg_req),
      .crystal_oscillator_stable (crystal_oscillator_stable),
      .radio_state               (radio_state),
      .calibrate_strobe          (calibrate_strobe),
      .reg_rdata                 (reg_rdata),
      .cal_start                 (cal_start),
      .chip_ready_low            (chip_ready_low),
      .oscillator_settled        (oscillator_settled)
   );

   always #2.5 core_clk = ~core_clk;

   // Pulses counted, not timed, so latency choices cannot mask misses
   always @(posedge core_clk) begin
      if (cal_start === 1'b1) cal_seen <= cal_seen + 1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Shortest wait for ready, in cycles, for a timeout setting
   function automatic integer po_lo(input integer sel);
      po_lo = (1 << RACPT_RIPPLE_BITS) * n_tab[sel];
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk) reg_req = '{1'b1, 1'b0, a, d};
      @(negedge core_clk) reg_req = '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge core_clk) reg_req = '0;
      chk(reg_rdata, exp);
      @(negedge core_clk) chk(reg_rdata, 8'h00);
   endtask

   // Cycles from oscillator stable until ready goes low
   task automatic po(output integer c);
      @(negedge core_clk) crystal_oscillator_stable = 1'b1;
      c = 0;
      while (chip_ready_low !== 1'b0 && c < 20000) begin
         @(negedge core_clk);
         c++;
      end
   endtask

   task automatic end_of_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      end_of_test;
   end

   initial begin
      repeat (6) @(negedge core_clk);
      reset_n = 1'b1;
      chk(chip_ready_low, 1'b1);
      rd(8'h17, 8'h04);
      wr(8'h17, 8'hFF);
      rd(8'h17, 8'h3F);
      wr(8'h16, 8'hAA);
      rd(8'h16, 8'h00);
      rd(8'h17, 8'h3F);
      wr(8'h17, 8'h04);
      repeat (3) begin
         @(negedge core_clk) calibrate_strobe = 1'b1;
         @(negedge core_clk) calibrate_strobe = 1'b0;
         cal_exp++;
      end
      for (m = 0; m < 4; m++) begin
         wr(8'h17, {2'b00, m[1:0], 4'h4});
         repeat (60) begin
            prev_st = radio_state;
            next_st = racpt_radio_t'(4'h1 << ($unsigned($random(seed)) % 4));
            @(negedge core_clk) radio_state = next_st;
            lv = (prev_st == RACPT_RX || prev_st == RACPT_TX)
                 && next_st == RACPT_IDLE;
            if (m == 1 && prev_st == RACPT_IDLE && next_st != RACPT_IDLE)
               cal_exp++;
            if (m == 2 && lv) cal_exp++;
            if (m == 3 && lv) begin
               leaves = (leaves + 1) % 4;
               if (leaves == 0) cal_exp++;
            end
            repeat (3) @(negedge core_clk);
         end
         repeat (3) @(negedge core_clk);
         chk(cal_seen, cal_exp);
      end
      for (s = 0; s < 4; s++) begin
         wr(8'h17, {4'h0, s[1:0], 2'b00});
         po(cyc);
         lo = po_lo(s);
         chk(cyc >= lo && cyc <= lo + 3, 16'h0001);
         chk(oscillator_settled, 1'b1);
         @(negedge core_clk) crystal_oscillator_stable = 1'b0;
         repeat (3) @(negedge core_clk);
         chk(chip_ready_low, 1'b1);
         chk(oscillator_settled, 1'b0);
      end
      // Interrupted start must not keep its partial count
      wr(8'h17, 8'h04);
      @(negedge core_clk) crystal_oscillator_stable = 1'b1;
      repeat (900) @(negedge core_clk);
      chk(chip_ready_low, 1'b1);
      crystal_oscillator_stable = 1'b0;
      repeat (2) @(negedge core_clk);
      po(cyc);
      chk(cyc >= po_lo(1) && cyc <= po_lo(1) + 3, 16'h0001);
      end_of_test;
   end
endmodule
